//--- hw/serial_mac_cfg_regs.sv
// AHB-Lite register bank for serial interface and MAC interface options
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
// register map, byte address is four times the index:
//   0x10 MAC control, 0x12 MAC interrupt enable, 0x13 MAC event status
//   0x1A fiber serial control, 0x30 bank status, 0x31 bank enable
//   0x32 bank clear (write one), 0x33 software reset (bit 0)
// hreadyout is tied high and hresp to OKAY; every access takes one cycle
// update-type fields: bypass permission, preamble pass, receive clock
module serial_mac_cfg_regs
  import serial_mac_cfg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic link_up_pulse,
  input wire logic link_up_by_bypass,
  input wire logic an_complete_raw,
  input wire fifo_evt_s fifo_evt,
  output logic an_complete_rpt,
  output logic tx_disable,
  output logic [2:0] amp_code,
  output applied_cfg_s applied_cfg,
  output logic irq
);
  // register storage
  logic [15:0] fiber_ctrl2_r;
  logic [15:0] mac_ctrl1_r;
  logic [15:0] mac_ien_r;
  logic byp_status_r;
  fifo_evt_s mac_stat_r;
  fifo_evt_s irq_stat_r;
  fifo_evt_s irq_en_r;
  logic byp_allow_r;
  logic pass_odd_r;
  logic rx_clk_on_r;
  logic ap_valid_r;
  logic ap_write_r;
  logic [7:0] ap_idx_r;
  logic wr_en;
  logic rd_stat;
  logic sw_reset;
  logic [15:0] wdata;
  logic [31:0] rdata_nxt;
  // bus decode
  logic addr_ok;
  logic rd_req;
  logic wr_fiber;
  logic wr_mac1;
  logic wr_ien;
  logic wr_irq_en;
  logic wr_irq_clr;
  // event routing
  fifo_evt_s stat_clr;
  fifo_evt_s ien_evt;
  fifo_evt_s irq_pend;

  // register index of a byte address
  function automatic logic [7:0] addr_idx(input logic [31:0] a);
    addr_idx = a[IDX_MSB:IDX_LSB];
  endfunction : addr_idx

  function automatic fifo_evt_s pick_evt(input logic [15:0] v);
    pick_evt.fifo_err = v[FIFO_ERR_BIT];
    pick_evt.idle_ins = v[IDLE_INS_BIT];
    pick_evt.idle_del = v[IDLE_DEL_BIT];
  endfunction : pick_evt

  function automatic logic [15:0] place_evt(input fifo_evt_s e);
    place_evt = 16'h0000;
    place_evt[FIFO_ERR_BIT] = e.fifo_err;
    place_evt[IDLE_INS_BIT] = e.idle_ins;
    place_evt[IDLE_DEL_BIT] = e.idle_del;
  endfunction : place_evt

  // always zero wait state, always OKAY: nothing here needs a second cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // only whole aligned words are taken; anything else is ignored silently
  assign addr_ok = hsel && (htrans == HTRANS_NONSEQ)
                   && (hsize == HSIZE_WORD) && (haddr[1:0] == 2'h0);
  assign rd_req = addr_ok && hready && !hwrite;

  // data-phase write strobes, one per writable register
  assign wdata = hwdata[15:0];
  assign stat_clr = pick_evt(wdata);
  assign wr_en = ap_valid_r && ap_write_r;
  assign wr_fiber = wr_en && (ap_idx_r == IDX_FIBER_CTRL2);
  assign wr_mac1 = wr_en && (ap_idx_r == IDX_MAC_CTRL1);
  assign wr_ien = wr_en && (ap_idx_r == IDX_MAC_IEN);
  assign wr_irq_en = wr_en && (ap_idx_r == IDX_IRQ_EN);
  assign wr_irq_clr = wr_en && (ap_idx_r == IDX_IRQ_CLR);
  assign sw_reset = wr_en && (ap_idx_r == IDX_SW_RESET)
                    && hwdata[SW_RESET_BIT];

  // address phase captured for the data phase that follows
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_r <= 1'b0;
    end else if (hready) begin
      ap_valid_r <= addr_ok;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_write_r <= 1'b0;
    end else if (hready) begin
      ap_write_r <= hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_idx_r <= 8'h00;
    end else if (hready) begin
      ap_idx_r <= addr_idx(haddr);
    end
  end

  // the status register clears on the edge that takes its read address
  assign rd_stat = rd_req && (addr_idx(haddr) == IDX_MAC_STAT);

  // read view of the addressed register; unmapped or unaligned reads give 0
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (addr_ok) begin
      unique case (addr_idx(haddr))
        IDX_FIBER_CTRL2: begin
          rdata_nxt[15:0] = fiber_ctrl2_r;
          rdata_nxt[BYP_ST_BIT] = byp_status_r;
        end
        IDX_MAC_CTRL1: rdata_nxt[15:0] = mac_ctrl1_r;
        IDX_MAC_IEN: rdata_nxt[15:0] = mac_ien_r;
        IDX_MAC_STAT: rdata_nxt[15:0] = place_evt(mac_stat_r);
        IDX_IRQ_STAT: rdata_nxt[15:0] = place_evt(irq_stat_r);
        IDX_IRQ_EN: rdata_nxt[15:0] = place_evt(irq_en_r);
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // read data comes from a flop so the bus sees no path from the address
  // decode to hrdata; it holds until the next read address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite) begin
      hrdata <= rdata_nxt;
    end
  end

  // control register writes; software reset leaves these written control values alone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fiber_ctrl2_r <= FIBER_CTRL2_RST;
    end else if (wr_fiber) begin
      fiber_ctrl2_r <= wdata & FIBER_CTRL2_WMASK;
    end
  end

  // reserved bits are stored as written; keeping them legal is software's job
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mac_ctrl1_r <= MAC_CTRL1_RST;
    end else if (wr_mac1) begin
      mac_ctrl1_r <= wdata;
    end
  end

  // interrupt enables are retain-type: software reset leaves them alone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mac_ien_r <= IEN_RST;
    end else if (wr_ien) begin
      mac_ien_r <= wdata;
    end
  end

  // update-type fields reach the datapath only on software reset, so a
  // disruptive change is never applied while a frame is in flight
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      byp_allow_r <= APPLIED_RST.bypass_allowed;
    end else if (sw_reset) begin
      byp_allow_r <= fiber_ctrl2_r[BYP_EN_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pass_odd_r <= APPLIED_RST.pass_odd_preamble;
    end else if (sw_reset) begin
      pass_odd_r <= mac_ctrl1_r[PASS_ODD_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_clk_on_r <= APPLIED_RST.rx_clk_always_on;
    end else if (sw_reset) begin
      rx_clk_on_r <= mac_ctrl1_r[RX_PWR_BIT];
    end
  end

  assign applied_cfg = '{bypass_allowed: byp_allow_r,
                         pass_odd_preamble: pass_odd_r,
                         rx_clk_always_on: rx_clk_on_r};

  // bypass status: status is cleared by software reset as its reset column says, except when a link-up pulse arrives in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      byp_status_r <= 1'b0;
    end else if (link_up_pulse) begin
      byp_status_r <= link_up_by_bypass && byp_allow_r;
    end else if (sw_reset) begin
      byp_status_r <= 1'b0;
    end
  end

  // outputs that follow the stored fields directly; no pending stage
  assign an_complete_rpt = an_complete_raw && !byp_status_r;
  assign tx_disable = fiber_ctrl2_r[TX_DIS_BIT];
  assign amp_code = fiber_ctrl2_r[AMP_LSB +: 3];

  // latched-high event bits clear on read or software reset; an event that
  // arrives in the clearing cycle wins so that it is never lost
  generate
    for (genvar i = 0; i < EVT_COUNT; i++) begin : g_evt
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          mac_stat_r[i] <= 1'b0;
        end else if (fifo_evt[i]) begin
          mac_stat_r[i] <= 1'b1;
        end else if (sw_reset || rd_stat) begin
          mac_stat_r[i] <= 1'b0;
        end
      end

      // bank-level sticky copy, cleared by writing one to its bit
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          irq_stat_r[i] <= 1'b0;
        end else if (fifo_evt[i]) begin
          irq_stat_r[i] <= 1'b1;
        end else if (wr_irq_clr && stat_clr[i]) begin
          irq_stat_r[i] <= 1'b0;
        end
      end
    end : g_evt
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_r <= '0;
    end else if (wr_irq_en) begin
      irq_en_r <= pick_evt(wdata);
    end
  end

  // both the device enable bits and the bank enable must allow an event;
  // the bank enable lets software mask without touching the device bits
  assign ien_evt = pick_evt(mac_ien_r & MAC_IEN_MASK);
  assign irq_pend = irq_stat_r & irq_en_r & ien_evt;

  always_comb begin
    irq = |irq_pend;
  end
endmodule : serial_mac_cfg_regs

//--- include/serial_mac_cfg_pkg.sv
// constants, register layout and carrier types for the serial/MAC config bank
package serial_mac_cfg_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_MAC_CTRL1 = 8'h10;
  localparam logic [7:0] IDX_MAC_IEN = 8'h12;
  localparam logic [7:0] IDX_MAC_STAT = 8'h13;
  localparam logic [7:0] IDX_FIBER_CTRL2 = 8'h1A;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h30;
  localparam logic [7:0] IDX_IRQ_EN = 8'h31;
  localparam logic [7:0] IDX_IRQ_CLR = 8'h32;
  localparam logic [7:0] IDX_SW_RESET = 8'h33;
  // fiber_serial_control_two fields
  localparam int BYP_EN_BIT = 6;
  localparam int BYP_ST_BIT = 5;
  localparam int FX_RSV_BIT = 4;
  localparam int TX_DIS_BIT = 3;
  localparam int AMP_LSB = 0;
  localparam logic [15:0] FIBER_CTRL2_RST = 16'h0042;
  localparam logic [15:0] FIBER_CTRL2_WMASK = 16'hFFDF;
  // mac_side_control_one fields
  localparam int PASS_ODD_BIT = 6;
  localparam int RX_PWR_BIT = 3;
  localparam logic [15:0] MAC_CTRL1_RST = 16'h4448;
  // interrupt enable / event bits
  localparam int FIFO_ERR_BIT = 7;
  localparam int IDLE_INS_BIT = 3;
  localparam int IDLE_DEL_BIT = 2;
  localparam logic [15:0] MAC_IEN_MASK = 16'h008C;
  localparam logic [15:0] IEN_RST = 16'h0000;
  localparam logic [2:0] AMP_RST = 3'h2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // register index field of a byte address, and the software reset bit
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  localparam int SW_RESET_BIT = 0;

  typedef struct packed {
    logic bypass_allowed;
    logic pass_odd_preamble;
    logic rx_clk_always_on;
  } applied_cfg_s;

  localparam applied_cfg_s APPLIED_RST = 3'h7;

  typedef struct packed {
    logic fifo_err;
    logic idle_ins;
    logic idle_del;
  } fifo_evt_s;

  localparam int EVT_COUNT = $bits(fifo_evt_s);
endpackage : serial_mac_cfg_pkg

//--- tb/link_side_model.sv
// behavioural link logic feeding the config bank
`timescale 1ns/1ps
module link_side_model
  import serial_mac_cfg_pkg::*;
(
  input wire logic hclk,
  output logic link_up_pulse,
  output logic link_up_by_bypass,
  output logic an_complete_raw,
  output fifo_evt_s fifo_evt
);
  initial begin
    link_up_pulse = 1'b0;
    link_up_by_bypass = 1'b0;
    an_complete_raw = 1'b0;
    fifo_evt = '0;
  end
  task automatic link_up(input logic byp);
    @(posedge hclk);
    link_up_pulse <= 1'b1;
    link_up_by_bypass <= byp;
    an_complete_raw <= 1'b1;
    @(posedge hclk);
    link_up_pulse <= 1'b0;
    // cause is only valid with the pulse, so show the other value after
    link_up_by_bypass <= ~byp;
  endtask : link_up
  task automatic event_pulse(input fifo_evt_s e);
    @(posedge hclk);
    fifo_evt <= e;
    @(posedge hclk);
    fifo_evt <= '0;
  endtask : event_pulse
endmodule : link_side_model

//--- tb/serial_mac_cfg_asserts.sv
// port assertions for the serial/MAC config bank
`timescale 1ns/1ps
module cfg_chk
  import serial_mac_cfg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic hwrite,
  input wire logic link_up_pulse,
  input wire logic link_up_by_bypass,
  input wire fifo_evt_s fifo_evt,
  input wire logic an_complete_rpt,
  input wire logic tx_disable,
  input wire logic [2:0] amp_code,
  input wire applied_cfg_s applied_cfg,
  input wire logic irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // a write lands one edge after its address phase, seen one edge later
  wire swr = hsel && hwrite && haddr == 32'h0000_00CC;
  wire fwr = hsel && hwrite && haddr == 32'h0000_0068;
  wire any_wr = hsel && hwrite;
  property p_rst; $rose(hresetn) |-> amp_code == AMP_RST && !tx_disable
    && !irq && applied_cfg == 3'h7; endproperty
  a_rst: assert property (p_rst) else $error("bad reset outputs");
  property p_byp; $changed(applied_cfg.bypass_allowed) |-> $past(swr, 2);
  endproperty
  a_byp: assert property (p_byp) else $error("bypass applied early");
  property p_odd; $changed(applied_cfg.pass_odd_preamble) |-> $past(swr, 2);
  endproperty
  a_odd: assert property (p_odd) else $error("preamble applied early");
  property p_rxc; $changed(applied_cfg.rx_clk_always_on) |-> $past(swr, 2);
  endproperty
  a_rxc: assert property (p_rxc) else $error("rx clk applied early");
  property p_tx; $changed(tx_disable) |-> $past(fwr, 2); endproperty
  a_tx: assert property (p_tx) else $error("tx disable moved");
  property p_amp; $changed(amp_code) |-> $past(fwr, 2); endproperty
  a_amp: assert property (p_amp) else $error("amplitude moved");
  property p_an; link_up_pulse && link_up_by_bypass
    && applied_cfg.bypass_allowed |=> !an_complete_rpt; endproperty
  a_an: assert property (p_an) else $error("an complete with bypass");
  property p_irq; $rose(irq) |-> $past(fifo_evt != 3'h0) || $past(any_wr, 2);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
endmodule : cfg_chk
bind serial_mac_cfg_regs cfg_chk i_chk (.hclk, .hresetn, .hsel, .haddr,
  .hwrite, .link_up_pulse, .link_up_by_bypass, .fifo_evt, .an_complete_rpt,
  .tx_disable, .amp_code, .applied_cfg, .irq);

//--- tb/tb.sv
// self-checking bench for the serial/MAC config bank
`timescale 1ns/1ps
module tb
  import serial_mac_cfg_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, an_complete_rpt;
  logic [31:0] haddr, hwdata, hrdata, rd, v, m;
  logic [1:0] htrans;
  logic link_up_pulse, link_up_by_bypass, an_complete_raw, tx_disable;
  logic [2:0] amp_code;
  fifo_evt_s fifo_evt;
  applied_cfg_s applied_cfg;
  int miscompares = 0;
  int num_checks = 0;
  serial_mac_cfg_regs i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize(HSIZE_WORD), .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .link_up_pulse, .link_up_by_bypass, .an_complete_raw,
    .fifo_evt, .an_complete_rpt, .tx_disable, .amp_code, .applied_cfg, .irq);
  link_side_model i_link (.hclk, .link_up_pulse, .link_up_by_bypass,
    .an_complete_raw, .fifo_evt);
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic check(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [31:0] a, wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
    #1;
  endtask : bus
  task automatic rdchk(input logic [31:0] a, exp);
    bus(1'b0, a, 32'h0);
    check(32'(hresp), 32'h0);
    check(rd, exp);
  endtask : rdchk
  task automatic t_defaults();
    rdchk(32'h68, 32'h42);
    rdchk(32'h40, 32'h4448);
    rdchk(32'h48, 32'h0);
    rdchk(32'h3FC, 32'h0);
    check(32'(applied_cfg), 32'h7);
    $display("defaults done");
  endtask : t_defaults
  task automatic t_fiber();
    // bit 5 is written high on purpose: it must read back as status only
    for (int c = 0; c < 8; c++) begin
      v = 32'h60 | c | ((c & 1) << 3);
      bus(1'b1, 32'h68, v);
      check(32'(amp_code), c);
      check(32'(tx_disable), c & 1);
      rdchk(32'h68, v & 32'hFFDF);
    end
    bus(1'b1, 32'h68, 32'h42);
    $display("fiber done");
  endtask : t_fiber
  task automatic t_update(input logic [31:0] mc, fc, exp);
    bus(1'b1, 32'h40, mc);
    bus(1'b1, 32'h68, fc);
    check(32'(applied_cfg), ~exp & 32'h7);
    bus(1'b1, 32'hCC, 32'h1);
    check(32'(applied_cfg), exp);
    rdchk(32'h40, mc);
    $display("update done");
  endtask : t_update
  task automatic t_bypass();
    i_link.link_up(1'b1);
    #1 check(32'(an_complete_rpt), 32'h0);
    rdchk(32'h68, 32'h62);
    bus(1'b1, 32'hCC, 32'h1);
    check(32'(an_complete_rpt), 32'h1);
    i_link.link_up(1'b0);
    #1 rdchk(32'h68, 32'h42);
    $display("bypass done");
  endtask : t_bypass
  task automatic t_irq();
    bus(1'b1, 32'hC4, 32'h8C);
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? 32'h80 : (32'h08 >> (i - 1));
      bus(1'b1, 32'h48, 32'h0);
      i_link.event_pulse(fifo_evt_s'(3'h4 >> i));
      #1 check(32'(irq), 32'h0);
      bus(1'b1, 32'h48, m);
      check(32'(irq), 32'h1);
      rdchk(32'h4C, m);
      rdchk(32'h4C, 32'h0);
      bus(1'b1, 32'hC8, m);
      check(32'(irq), 32'h0);
    end
    $display("irq done");
  endtask : t_irq
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hwdata = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_defaults();
    t_fiber();
    t_update(32'h4400, 32'h02, 32'h0);
    t_update(32'h4448, 32'h42, 32'h7);
    t_bypass();
    t_irq();
    tally_and_finish();
  end
  initial begin
    // the run needs well under 1000 cycles
    #50000;
    miscompares++;
    tally_and_finish();
  end
endmodule : tb
